// *** inc/flash_front_defines.vh ***
// constants for the serial flash command front end
// assumes: single clk at 125 MHz, spi pins sampled through three flops
// What this block does
// - sample rising serial edge, shift out falling
// - dual read turns input line into output
// - all bytes travel msb first
// - unknown opcode ignored until reselect
// - early deselect performs nothing, back idle
// - three address bytes, top byte ignored
// - 0bh one dummy, 03h none
// - page and block erases take three address bytes only
// - chip erase 60h c7h 62h, no bytes
// - program 02h, address, then data bytes
// - status read 05h, writes 01h 31h one byte
// - otp program 9bh, otp read two dummies
// - id read 9fh, legacy 15h one byte plus msb of second, then released
// - power-down opcodes take no bytes
// - read address counter advances automatically
// - after dummies, read data shifts out msb first
// - address wraps ffffh to 0000h seamlessly
// - deselect ends read, output released
// - dual read bit7 on output, bit6 second lane
// - output released whenever deselected
`ifndef FLASH_FRONT_DEFINES_VH
`define FLASH_FRONT_DEFINES_VH
// ----------------------------------------
// opcodes
// ----------------------------------------
`define OP_READ_FAST 8'h0b
`define OP_READ_SLOW 8'h03
`define OP_READ_DUAL 8'h3b
`define OP_PAGE_ERASE 8'h81
`define OP_BLK4_ERASE 8'h20
`define OP_BLK32_ERASE_A 8'h52
`define OP_BLK32_ERASE_B 8'hd8
`define OP_CHIP_ERASE_A 8'h60
`define OP_CHIP_ERASE_B 8'hc7
`define OP_CHIP_ERASE_C 8'h62
`define OP_PROGRAM 8'h02
`define OP_WR_ENABLE 8'h06
`define OP_WR_DISABLE 8'h04
`define OP_OTP_PROGRAM 8'h9b
`define OP_OTP_READ 8'h77
`define OP_STATUS_READ 8'h05
`define OP_STATUS_WR1 8'h01
`define OP_STATUS_WR2 8'h31
`define OP_RESET 8'hf0
`define OP_ID_READ 8'h9f
`define OP_ID_LEGACY 8'h15
`define OP_DEEP_PD 8'hb9
`define OP_RESUME_PD 8'hab
`define OP_ULTRA_PD 8'h79
// ----------------------------------------
// data-phase kinds
// ----------------------------------------
`define DK_NONE 3'h0
`define DK_READ_ARRAY 3'h1
`define DK_WRITE_MANY 3'h2
`define DK_WRITE_ONE 3'h3
`define DK_READ_OTHER 3'h4
// ----------------------------------------
// widths and limits
// ----------------------------------------
`define ADDR_BYTES 2'h3
`define ARRAY_ADDR_W 16
`define MAX_ID_BYTES 3'h4
`define LEGACY_ID_BYTES 3'h2
`define FIFO_DEPTH 8
`define FIFO_AW 3
`define RST_BIT_CNT 3'h0
`endif

// *** src/word_fifo.v ***
// ----------------------------------------
// small synchronous fifo, flop storage
// ----------------------------------------
// assumes one clock, synchronous active-high reset
module word_fifo #(
   parameter WIDTH = 8,
   parameter DEPTH = 8,
   parameter AW = 3
) (
   input wire clk,
   input wire rst,
   input wire in_valid,
   output wire in_ready,
   input wire [WIDTH-1:0] in_data,
   output wire out_valid,
   input wire out_ready,
   output wire [WIDTH-1:0] out_data
);
   reg [WIDTH-1:0] mem_r [0:DEPTH-1];
   reg [AW-1:0] wp_r;
   reg [AW-1:0] rp_r;
   reg [AW:0] cnt_r;
   wire push = in_valid && in_ready;
   wire pop = out_valid && out_ready;
   assign in_ready = (cnt_r != DEPTH[AW:0]);
   assign out_valid = (cnt_r != {(AW+1){1'b0}});
   assign out_data = mem_r[rp_r];
   always @(posedge clk) begin
      if (push) begin
         mem_r[wp_r] <= in_data;
      end
   end
   always @(posedge clk) begin
      if (rst) begin
         wp_r <= {AW{1'b0}};
         rp_r <= {AW{1'b0}};
         cnt_r <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wp_r <= (wp_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wp_r + 1'b1;
         end
         if (pop) begin
            rp_r <= (rp_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rp_r + 1'b1;
         end
         if (push && !pop) begin
            cnt_r <= cnt_r + 1'b1;
         end else if (pop && !push) begin
            cnt_r <= cnt_r - 1'b1;
         end
      end
   end
endmodule // word_fifo

// *** src/flash_front.v ***
// serial flash command front end: spi slave, opcode check, read streams
// assumes spi pins are asynchronous to clk and serial clock well below clk/4;
// array bytes come from an external read port answering in the next cycle
`include "flash_front_defines.vh"
module flash_front (
   input wire clk,
   input wire rst,
   input wire cs_n_pin,
   input wire sck_pin,
   input wire si_in,
   output reg si_out,
   output reg si_oe,
   output reg so_out,
   output reg so_oe,
   output reg [15:0] mem_addr,
   output reg mem_rd,
   input wire [7:0] mem_rdata,
   output reg [7:0] cmd_opcode,
   output reg [15:0] cmd_addr,
   output reg cmd_start,
   output reg cmd_done,
   output reg cmd_abort,
   output wire wr_valid,
   input wire wr_ready,
   output wire [7:0] wr_data,
   output wire wr_overflow,
   input wire [7:0] aux_rdata,
   output reg aux_rd
);
   // ----------------------------------------
   // command table
   // ----------------------------------------
   // returns {known, addr_bytes[1:0], dummies[1:0], kind[2:0]}
   function [7:0] decode;
      input [7:0] op;
      begin
         case (op)
            `OP_READ_FAST, `OP_READ_DUAL: decode = {1'b1, 2'h3, 2'h1, `DK_READ_ARRAY};
            `OP_READ_SLOW: decode = {1'b1, 2'h3, 2'h0, `DK_READ_ARRAY};
            `OP_PAGE_ERASE, `OP_BLK4_ERASE, `OP_BLK32_ERASE_A, `OP_BLK32_ERASE_B:
               decode = {1'b1, 2'h3, 2'h0, `DK_NONE};
            `OP_CHIP_ERASE_A, `OP_CHIP_ERASE_B, `OP_CHIP_ERASE_C:
               decode = {1'b1, 2'h0, 2'h0, `DK_NONE};
            `OP_PROGRAM, `OP_OTP_PROGRAM: decode = {1'b1, 2'h3, 2'h0, `DK_WRITE_MANY};
            `OP_OTP_READ: decode = {1'b1, 2'h3, 2'h2, `DK_READ_OTHER};
            `OP_STATUS_READ, `OP_ID_READ, `OP_ID_LEGACY:
               decode = {1'b1, 2'h0, 2'h0, `DK_READ_OTHER};
            `OP_STATUS_WR1, `OP_STATUS_WR2, `OP_RESET:
               decode = {1'b1, 2'h0, 2'h0, `DK_WRITE_ONE};
            `OP_WR_ENABLE, `OP_WR_DISABLE, `OP_DEEP_PD, `OP_RESUME_PD, `OP_ULTRA_PD:
               decode = {1'b1, 2'h0, 2'h0, `DK_NONE};
            default: decode = 8'h00;
         endcase
      end
   endfunction

   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   // three flops each; a change counts once the second and third agree
   reg [2:0] cs_s_r;
   reg [2:0] sck_s_r;
   reg [2:0] si_s_r;
   reg cs_n_r;
   reg sck_r;
   reg sck_prev_r;
   reg si_r;
   always @(posedge clk) begin
      if (rst) begin
         cs_s_r <= 3'h7;
         sck_s_r <= 3'h0;
         si_s_r <= 3'h0;
         cs_n_r <= 1'b1;
         sck_r <= 1'b0;
         sck_prev_r <= 1'b0;
         si_r <= 1'b0;
      end else begin
         cs_s_r <= {cs_s_r[1:0], cs_n_pin};
         sck_s_r <= {sck_s_r[1:0], sck_pin};
         si_s_r <= {si_s_r[1:0], si_in};
         if (cs_s_r[1] == cs_s_r[2]) begin
            cs_n_r <= cs_s_r[2];
         end
         if (sck_s_r[1] == sck_s_r[2]) begin
            sck_r <= sck_s_r[2];
         end
         sck_prev_r <= sck_r;
         // data passes the same agreement filter so it lines up with the clock edge
         if (si_s_r[1] == si_s_r[2]) begin
            si_r <= si_s_r[2];
         end
      end
   end
   // edges only count while selected, so idle level (mode 0 or 3) is irrelevant
   wire sck_rise = sck_r && !sck_prev_r && !cs_n_r;
   wire sck_fall = !sck_r && sck_prev_r && !cs_n_r;
   wire si_bit = si_r;

   // ----------------------------------------
   // receive side
   // ----------------------------------------
   localparam ST_IDLE = 3'h0;
   localparam ST_OPCODE = 3'h1;
   localparam ST_ADDR = 3'h2;
   localparam ST_DUMMY = 3'h3;
   localparam ST_DATA = 3'h4;
   localparam ST_IGNORE = 3'h5;

   reg [2:0] state_r;
   reg [2:0] bit_cnt_r;
   reg [7:0] shift_r;
   reg [1:0] addr_left_r;
   reg [1:0] dummy_left_r;
   reg [2:0] kind_r;
   reg dual_r;
   reg [15:0] addr_r;
   reg [2:0] out_bytes_r;
   reg wr_push_r;
   reg [7:0] wr_byte_r;
   reg wr_lost_r;
   reg got_data_r;
   reg cs_prev_r;
   wire [7:0] dec = decode({shift_r[6:0], si_bit});
   wire [7:0] byte_in = {shift_r[6:0], si_bit};
   // bit_cnt_r keeps running through the data phase and marks every byte boundary
   wire byte_end = sck_rise && (bit_cnt_r == 3'h7);
   wire fifo_in_ready;

   always @(posedge clk) begin
      if (rst) begin
         state_r <= ST_IDLE;
         bit_cnt_r <= `RST_BIT_CNT;
         shift_r <= 8'h00;
         addr_left_r <= 2'h0;
         dummy_left_r <= 2'h0;
         kind_r <= `DK_NONE;
         dual_r <= 1'b0;
         addr_r <= 16'h0000;
         cmd_opcode <= 8'h00;
         cmd_addr <= 16'h0000;
         cmd_start <= 1'b0;
         cmd_done <= 1'b0;
         cmd_abort <= 1'b0;
         wr_push_r <= 1'b0;
         wr_byte_r <= 8'h00;
         wr_lost_r <= 1'b0;
         got_data_r <= 1'b0;
         cs_prev_r <= 1'b1;
      end else begin
         // the deselect edge is seen once, so done and abort pulse for one cycle only
         cs_prev_r <= cs_n_r;
         cmd_start <= 1'b0;
         cmd_done <= 1'b0;
         cmd_abort <= 1'b0;
         wr_push_r <= 1'b0;
         if (cs_n_r) begin
            // deselect: finish only a complete, byte-aligned command
            if (!cs_prev_r) begin
               if (state_r == ST_DATA && bit_cnt_r == 3'h0 &&
                   (kind_r == `DK_NONE || got_data_r)) begin
                  cmd_done <= 1'b1;
               end else if (state_r != ST_IDLE && state_r != ST_IGNORE) begin
                  cmd_abort <= 1'b1;
               end
            end
            state_r <= ST_IDLE;
            bit_cnt_r <= 3'h0;
            dual_r <= 1'b0;
         end else begin
            if (state_r == ST_IDLE) begin
               state_r <= ST_OPCODE;
               bit_cnt_r <= 3'h0;
               got_data_r <= 1'b0;
               wr_lost_r <= 1'b0;
            end
            if (sck_rise) begin
               shift_r <= byte_in;
               bit_cnt_r <= bit_cnt_r + 3'h1;
            end
            if (byte_end) begin
               case (state_r)
                  ST_OPCODE: begin
                     cmd_opcode <= byte_in;
                     kind_r <= dec[2:0];
                     addr_left_r <= dec[6:5];
                     dummy_left_r <= dec[4:3];
                     // the second lane turns around only for the dual read
                     dual_r <= (byte_in == `OP_READ_DUAL);
                     if (!dec[7]) begin
                        state_r <= ST_IGNORE;
                     end else if (dec[6:5] != 2'h0) begin
                        state_r <= ST_ADDR;
                     end else begin
                        state_r <= ST_DATA;
                        cmd_start <= 1'b1;
                     end
                  end
                  ST_ADDR: begin
                     // top address byte shifts out of the 16-bit field
                     addr_r <= {addr_r[7:0], byte_in};
                     addr_left_r <= addr_left_r - 2'h1;
                     if (addr_left_r == 2'h1) begin
                        cmd_addr <= {addr_r[7:0], byte_in};
                        if (dummy_left_r != 2'h0) begin
                           state_r <= ST_DUMMY;
                        end else begin
                           state_r <= ST_DATA;
                           cmd_start <= 1'b1;
                        end
                     end
                  end
                  ST_DUMMY: begin
                     // value discarded, only counted
                     dummy_left_r <= dummy_left_r - 2'h1;
                     if (dummy_left_r == 2'h1) begin
                        state_r <= ST_DATA;
                        cmd_start <= 1'b1;
                     end
                  end
                  ST_DATA: begin
                     if (kind_r == `DK_WRITE_MANY || (kind_r == `DK_WRITE_ONE && !got_data_r)) begin
                        wr_push_r <= 1'b1;
                        wr_byte_r <= byte_in;
                        got_data_r <= 1'b1;
                        if (!fifo_in_ready) begin
                           wr_lost_r <= 1'b1;
                        end
                     end else if (kind_r == `DK_WRITE_ONE) begin
                        state_r <= ST_IGNORE;
                     end
                  end
                  default: state_r <= state_r;
               endcase
            end
         end
      end
   end

   // ----------------------------------------
   // write data buffer
   // ----------------------------------------
   // the serial master cannot be stalled; a full buffer drops and flags the byte
   word_fifo #(
      .WIDTH(8),
      .DEPTH(`FIFO_DEPTH),
      .AW(`FIFO_AW)
   ) wr_buf (
      .clk(clk),
      .rst(rst),
      .in_valid(wr_push_r),
      .in_ready(fifo_in_ready),
      .in_data(wr_byte_r),
      .out_valid(wr_valid),
      .out_ready(wr_ready),
      .out_data(wr_data)
   );
   assign wr_overflow = wr_lost_r;

   // ----------------------------------------
   // transmit side
   // ----------------------------------------
   reg [7:0] tx_r;
   reg [1:0] tx_cnt_r;
   reg tx_active_r;
   wire is_array = (kind_r == `DK_READ_ARRAY);
   wire is_read = is_array || (kind_r == `DK_READ_OTHER);
   // id readouts have a fixed length; a status poll may run on without end
   wire id_limit = (cmd_opcode == `OP_ID_LEGACY && out_bytes_r == `LEGACY_ID_BYTES) ||
                   (cmd_opcode == `OP_ID_READ && out_bytes_r == `MAX_ID_BYTES);
   // array and side registers share one shifter; only the byte source differs
   wire [7:0] next_byte = is_array ? mem_rdata : aux_rdata;

   always @(posedge clk) begin
      if (rst) begin
         tx_r <= 8'h00;
         tx_cnt_r <= 2'h0;
         tx_active_r <= 1'b0;
         out_bytes_r <= 3'h0;
         mem_addr <= 16'h0000;
         mem_rd <= 1'b0;
         aux_rd <= 1'b0;
         so_out <= 1'b0;
         so_oe <= 1'b0;
         si_out <= 1'b0;
         si_oe <= 1'b0;
      end else begin
         mem_rd <= 1'b0;
         aux_rd <= 1'b0;
         if (cs_n_r) begin
            tx_active_r <= 1'b0;
            so_oe <= 1'b0;
            si_oe <= 1'b0;
            out_bytes_r <= 3'h0;
         end else if (cmd_start && is_read) begin
            // fetch first byte; data lands well before the next falling edge
            mem_addr <= cmd_addr;
            mem_rd <= is_array;
            aux_rd <= !is_array;
            tx_cnt_r <= 2'h0;
         end else if (state_r == ST_DATA && is_read && sck_fall && !id_limit) begin
            if (!tx_active_r || tx_cnt_r == 2'h0) begin
               // load a fresh byte and drive its msb
               tx_active_r <= 1'b1;
               // saturate so a long poll never wraps back into an id limit
               out_bytes_r <= (out_bytes_r == 3'h7) ? out_bytes_r : out_bytes_r + 3'h1;
               so_oe <= 1'b1;
               if (dual_r) begin
                  so_out <= next_byte[7];
                  si_out <= next_byte[6];
                  si_oe <= 1'b1;
                  tx_r <= {next_byte[5:0], 2'b00};
                  tx_cnt_r <= 2'h3;
               end else begin
                  so_out <= next_byte[7];
                  tx_r <= {next_byte[6:0], 1'b0};
                  tx_cnt_r <= 2'h3;
               end
               // counter wraps ffffh to 0000h with no gap
               mem_addr <= mem_addr + 16'h0001;
               mem_rd <= is_array;
               aux_rd <= !is_array;
            end else begin
               if (dual_r) begin
                  so_out <= tx_r[7];
                  si_out <= tx_r[6];
                  tx_r <= {tx_r[5:0], 2'b00};
                  tx_cnt_r <= tx_cnt_r - 2'h1;
               end else begin
                  so_out <= tx_r[7];
                  tx_r <= {tx_r[6:0], 1'b0};
               end
            end
         end else if (state_r == ST_DATA && is_read && sck_fall) begin
            // id readout over: release the line rather than repeat the last bit
            so_oe <= 1'b0;
         end else if (!dual_r && sck_rise && tx_active_r) begin
            // single lane: 8 bits per byte, count by rising edges
            tx_cnt_r <= (bit_cnt_r == 3'h7) ? 2'h0 : 2'h1;
         end
      end
   end
endmodule // flash_front

// *** testbench/flash_front_assertions.sv ***
// port-level checks for the flash command front end
// assumes serial clock phases of at least four system clocks
`include "flash_front_defines.vh"
module flash_front_assertions (
   input wire logic clk,
   input wire logic rst,
   input wire logic cs_n_pin,
   input wire logic sck_pin,
   input wire logic so_out,
   input wire logic so_oe,
   input wire logic si_oe,
   input wire logic [15:0] mem_addr,
   input wire logic mem_rd,
   input wire logic [7:0] cmd_opcode,
   input wire logic [15:0] cmd_addr,
   input wire logic cmd_start,
   input wire logic cmd_done,
   input wire logic cmd_abort,
   input wire logic wr_valid,
   input wire logic wr_ready,
   input wire logic [7:0] wr_data
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] last_addr_r;
   logic first_r;
   default clocking dc @(posedge clk);
   endclocking
   default disable iff (rst);
   // ------
   // helpers
   // ------
   // the first fetch of a command has no predecessor to step from
   always @(posedge clk) begin
      if (mem_rd) begin
         last_addr_r <= mem_addr;
      end
      if (rst) begin
         first_r <= 1'b1;
      end else if (mem_rd) begin
         first_r <= 1'b0;
      end else if (cmd_start) begin
         first_r <= 1'b1;
      end
   end
   sequence unselected_s;
      cs_n_pin [*6];
   endsequence
   sequence read_go_s;
      cmd_start && (cmd_opcode == `OP_READ_SLOW || cmd_opcode == `OP_READ_FAST
         || cmd_opcode == `OP_READ_DUAL);
   endsequence
   // ------
   // checks
   // ------
   so_idle_a: assert property (unselected_s |-> !so_oe)
      else $error("serial output driven while deselected");
   lane_idle_a: assert property (unselected_s |-> !si_oe)
      else $error("second lane driven while deselected");
   dual_lane_a: assert property (si_oe |-> so_oe && cmd_opcode == `OP_READ_DUAL)
      else $error("second lane driven outside dual read");
   read_fetch_a: assert property (read_go_s |-> ##[0:2] (mem_rd && mem_addr == cmd_addr))
      else $error("read did not fetch its start address");
   addr_step_a: assert property (mem_rd && !first_r && !cmd_start |->
      mem_addr == last_addr_r + 16'h0001)
      else $error("array address did not step by one");
   pulse_excl_a: assert property ($onehot0({cmd_start, cmd_done, cmd_abort}))
      else $error("command pulses overlap");
   end_deselect_a: assert property (cmd_done || cmd_abort |-> $past(cs_n_pin, 2))
      else $error("command ended while selected");
   so_fall_a: assert property ($changed(so_out) && so_oe |-> !sck_pin && !$past(sck_pin, 3))
      else $error("serial output changed away from a falling edge");
   fifo_hold_a: assert property (wr_valid && !wr_ready |=> wr_valid && $stable(wr_data))
      else $error("write data withdrawn before taken");
endmodule // flash_front_assertions
bind flash_front flash_front_assertions u_chk (.clk, .rst, .cs_n_pin, .sck_pin, .so_out, .so_oe,
   .si_oe, .mem_addr, .mem_rd, .cmd_opcode, .cmd_addr, .cmd_start, .cmd_done, .cmd_abort,
   .wr_valid, .wr_ready, .wr_data);

// *** testbench/spi_host_model.sv ***
// serial master model: framing, byte exchange, dual-lane receive
// assumes the bench owns clk; each serial clock phase lasts HALF system clocks
module spi_host_model #(
   parameter int HALF = 8
) (
   input wire logic clk,
   input wire logic so_line,
   input wire logic sio_line,
   output logic cs_n,
   output logic sck,
   output logic si_drv,
   output logic si_en
);
   timeunit 1ns;
   timeprecision 1ps;
   logic idle_r = 1'b0;
   initial begin
      cs_n = 1'b1;
      sck = 1'b0;
      si_drv = 1'b0;
      si_en = 1'b1;
   end
   task automatic wait_half();
      repeat (HALF) @(posedge clk);
      #1;
   endtask
   // clock idles at cpol and stands still between frames
   task automatic frame_begin(input logic cpol);
      @(posedge clk);
      #1;
      idle_r = cpol;
      sck = cpol;
      si_en = 1'b1;
      wait_half();
      cs_n = 1'b0;
      wait_half();
   endtask
   task automatic byte_x(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--) begin
         sck = 1'b0;
         si_drv = tx[i];
         wait_half();
         rx[i] = so_line;
         sck = 1'b1;
         wait_half();
      end
   endtask
   // lane released: the bench shows the inverse of the last bit until the device drives
   task automatic dual_rx(output logic [7:0] rx);
      si_en = 1'b0;
      for (int i = 3; i >= 0; i--) begin
         sck = 1'b0;
         wait_half();
         rx[2 * i + 1] = so_line;
         rx[2 * i] = sio_line;
         sck = 1'b1;
         wait_half();
      end
   endtask
   task automatic frame_end();
      sck = idle_r;
      wait_half();
      cs_n = 1'b1;
      wait_half();
      wait_half();
   endtask
endmodule // spi_host_model

// *** testbench/tb_serial_flash_cmd_front_end.sv ***
// self-checking bench for the flash command front end
// assumes the host model in its own file and array/aux bytes answered next cycle
module tb_serial_flash_cmd_front_end;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, rst = 1'b1, wr_ready = 1'b0, cs_n, sck, si_drv, si_en;
   logic [7:0] mem_rdata = 8'h00, aux_rdata = 8'h00, cmd_opcode, wr_data, rx;
   logic [15:0] mem_addr, cmd_addr;
   logic si_out, si_oe, so_out, so_oe, mem_rd, cmd_start, cmd_done, cmd_abort;
   logic wr_valid, wr_overflow, aux_rd;
   int n_errors = 0, num_checks = 0, n_start = 0, n_done = 0, n_abort = 0;
   wire so_line = so_oe ? so_out : 1'bz;
   wire si_in = si_oe ? si_out : (si_en ? si_drv : ~si_drv);
   wire cs_n_pin = cs_n;
   wire sck_pin = sck;
   flash_front u_dut (.clk, .rst, .cs_n_pin, .sck_pin, .si_in, .si_out, .si_oe, .so_out, .so_oe,
      .mem_addr, .mem_rd, .mem_rdata, .cmd_opcode, .cmd_addr, .cmd_start, .cmd_done,
      .cmd_abort, .wr_valid, .wr_ready, .wr_data, .wr_overflow, .aux_rdata, .aux_rd);
   spi_host_model #(.HALF(8)) host (.clk, .so_line, .sio_line(si_in), .cs_n, .sck, .si_drv,
      .si_en);
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   function automatic logic [7:0] pat(input logic [15:0] a);
      return a[7:0] + a[15:8] + 8'h3c;
   endfunction
   always @(posedge clk) begin
      n_start <= n_start + (cmd_start === 1'b1);
      n_done <= n_done + (cmd_done === 1'b1);
      n_abort <= n_abort + (cmd_abort === 1'b1);
      if (mem_rd) mem_rdata <= pat(mem_addr);
      if (aux_rd) aux_rdata <= aux_rdata + 8'h11;
   end
   // ------
   // shared tasks
   // ------
   task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
      num_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic end_sim();
      $display("checks %0d mismatches %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic cmd(input logic [7:0] op, input int na, input logic [23:0] a, input logic cpol);
      n_start = 0;
      n_done = 0;
      n_abort = 0;
      host.frame_begin(cpol);
      host.byte_x(op, rx);
      for (int k = na - 1; k >= 0; k--) host.byte_x(a[8 * k +: 8], rx);
   endtask
   // bounded wait: a fifo that never delivers ends the run
   task automatic drain(input int n, input logic [7:0] first);
      int got;
      got = 0;
      wr_ready = 1'b1;
      for (int k = 0; k < 40 && got < n; k++) begin
         if (wr_valid === 1'b1) begin
            check("fifo byte", first + got[7:0], wr_data);
            got++;
         end
         @(posedge clk);
         #1;
      end
      wr_ready = 1'b0;
      check("fifo count", n, got);
      if (got != n) end_sim();
   endtask
   // ------
   // scenarios
   // ------
   task automatic t_read_slow();
      cmd(8'h03, 3, 24'h5afffe, 1'b0);
      for (int k = 0; k < 3; k++) begin
         host.byte_x(8'h00, rx);
         check("slow read byte", pat(16'hfffe + k), rx);
      end
      host.frame_end();
      check("slow read addr", 16'hfffe, cmd_addr);
      check("slow read starts", 1, n_start);
      $display("test slow read done");
   endtask
   task automatic t_read_fast();
      cmd(8'h0b, 3, 24'hff1234, 1'b1);
      host.byte_x(8'ha5, rx);
      for (int k = 0; k < 2; k++) begin
         host.byte_x(8'h00, rx);
         check("fast read byte", pat(16'h1234 + k), rx);
      end
      host.frame_end();
      check("fast read opcode", 8'h0b, cmd_opcode);
      $display("test fast read done");
   endtask
   task automatic t_read_dual();
      cmd(8'h3b, 3, 24'h00ffff, 1'b0);
      host.byte_x(8'h3c, rx);
      for (int k = 0; k < 2; k++) begin
         host.dual_rx(rx);
         check("dual read byte", pat(16'hffff + k), rx);
      end
      host.frame_end();
      check("dual read starts", 1, n_start);
      $display("test dual read done");
   endtask
   task automatic t_no_data();
      logic [7:0] ops [12] = '{8'h81, 8'h20, 8'h52, 8'hd8, 8'h60, 8'hc7, 8'h62, 8'h06,
         8'h04, 8'hb9, 8'hab, 8'h79};
      for (int k = 0; k < 12; k++) begin
         cmd(ops[k], (k < 4) ? 3 : 0, 24'h00abcd, k[0]);
         host.frame_end();
         check("opcode seen", ops[k], cmd_opcode);
         check("opcode done", 1, n_done);
         check("opcode abort", 0, n_abort);
      end
      $display("test no-data opcodes done");
   endtask
   task automatic t_aux_reads();
      logic [7:0] prev;
      logic [7:0] ops [3] = '{8'h05, 8'h9f, 8'h77};
      for (int k = 0; k < 3; k++) begin
         cmd(ops[k], (k == 2) ? 3 : 0, 24'h000010, k[0]);
         if (k == 2) begin
            host.byte_x(8'h00, rx);
            host.byte_x(8'h00, rx);
         end
         host.byte_x(8'h00, prev);
         host.byte_x(8'h00, rx);
         check("aux byte step", prev + 8'h11, rx);
         host.frame_end();
      end
      cmd(8'h15, 0, 24'h000000, 1'b0);
      repeat (3) host.byte_x(8'h00, rx);
      host.frame_end();
      check("legacy id released", 8'hzz, rx);
      $display("test aux reads done");
   endtask
   task automatic t_writes();
      logic [7:0] ops [3] = '{8'h01, 8'h31, 8'hf0};
      for (int k = 0; k < 3; k++) begin
         cmd(ops[k], 0, 24'h000000, k[0]);
         host.byte_x(8'h10, rx);
         host.byte_x(8'h99, rx);
         host.frame_end();
         drain(1, 8'h10);
      end
      cmd(8'h9b, 3, 24'h000020, 1'b0);
      host.byte_x(8'h21, rx);
      host.frame_end();
      check("otp program done", 1, n_done);
      drain(1, 8'h21);
      cmd(8'h02, 3, 24'h000100, 1'b1);
      for (int k = 0; k < 9; k++) host.byte_x(8'h10 + k[7:0], rx);
      host.frame_end();
      check("overflow flag", 1, wr_overflow);
      check("program done", 1, n_done);
      drain(8, 8'h10);
      $display("test writes done");
   endtask
   task automatic t_bad();
      cmd(8'h03, 2, 24'h001234, 1'b0);
      host.frame_end();
      check("short address abort", 1, n_abort);
      check("short address other", 0, n_start + n_done);
      cmd(8'h5e, 0, 24'h000000, 1'b1);
      repeat (5) host.byte_x(8'h03, rx);
      host.frame_end();
      check("unknown opcode pulses", 0, n_start + n_done + n_abort);
      check("unknown opcode output", 8'hzz, rx);
      $display("test bad sequences done");
   endtask
   initial begin
      repeat (20) @(posedge clk);
      #1;
      rst = 1'b0;
      repeat (4) @(posedge clk);
      t_read_slow();
      t_read_fast();
      t_read_dual();
      t_no_data();
      t_aux_reads();
      t_writes();
      t_bad();
      end_sim();
   end
endmodule // tb_serial_flash_cmd_front_end
